/* File: hw/iws_irq_wake.sv */
// What this block does
// R1: reset on power-on, pin low, enabled watchdog
// R2: pin reset while running keeps cause bits
// R3: pin wake from sleep: timeout 1, power-down 0
// R4: low-voltage: running keeps, sleeping gives 1/0
// R5: watchdog while running: timeout 0, power-down kept
// R6: watchdog wake from sleep clears both bits
// R7: pin-change wake sets timeout, clears power-down
// R8: power-on, watchdog-clear, sleep, timeout update bits
// R9: five sources: timer, port, two externals, comparator
// R10: software reads port before enabling change
// R11: port wake only if enabled before sleep
// R12: wake continues, or vectors if global enabled
// R13: external inputs filtered under eight clocks
// R14: flag bits per request, separate mask bits
// R15: enable/disable instructions drive global enable
// R16: enabled interrupt fetches from fixed vector
// R17: masked-on flags set regardless of global enable
// R18: flag read returns flags AND masks
// R19: return instruction ends routine, re-enables global
// R20: entry saves accumulator, R1, R3, R4 bits
// R21: service routine clears its flag first
// R22: shared pin: interrupt, then comparator, then gpio
// R23: comparator flag on every change, software clears
// R24: one shared vector, no hardware priority
`timescale 1ns/1ps
`include "iws_regs.svh"

module iws_irq_wake
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// reset sources, pins
	input wire logic power_on_in,
	input wire logic reset_pin_n_in,
	input wire logic low_voltage_reset_in,
	// watchdog, same clock
	input wire logic wdt_timeout_in,
	input wire logic wdt_enable_in,
	// instruction strobes from the sequencer
	input wire logic watchdog_clear_instr_in,
	input wire logic sleep_instr_in,
	input wire logic global_irq_on_instr_in,
	input wire logic global_irq_off_instr_in,
	input wire logic irq_return_instr_in,
	// context to save on entry
	input wire logic [7:0] acc_in,
	input wire logic [1:0] r1_in,
	input wire logic [2:0] r3_in,
	input wire logic [7:0] r4_in,
	// interrupt sources
	input wire logic timer_counter_ovf_in,
	input wire logic [`IWS_PORT_W-1:0] port_pins_in,
	input wire logic ext_irq_zero_in,
	input wire logic ext_irq_one_in,
	input wire logic comparator_result_bit_in,
	// software access
	input wire logic port_rd_in,
	input wire logic flag_wr_in,
	input wire logic [`IWS_NSRC-1:0] flag_wr_data_in,
	input wire logic mask_wr_in,
	input wire logic [`IWS_NSRC-1:0] mask_wr_data_in,
	// configuration
	input wire logic noise_filter_en_in,
	input wire logic ext_irq_one_select_in,
	input wire logic [1:0] comparator_pin_select_in,
	input wire logic gpio_out_val_in,
	input wire logic gpio_oe_in,
	// reset and status
	output logic reset_req_out,
	output logic timeout_bit_out,
	output logic power_down_bit_out,
	output logic sleeping_out,
	output logic wake_out,
	// interrupt entry and return
	output logic global_irq_en_out,
	output logic irq_take_out,
	output logic [`IWS_VEC_W-1:0] vector_out,
	output logic restore_valid_out,
	output logic [7:0] acc_out,
	output logic [1:0] r1_out,
	output logic [2:0] r3_out,
	output logic [7:0] r4_out,
	// flag and mask readback
	output logic [`IWS_NSRC-1:0] flag_rd_out,
	output logic [`IWS_NSRC-1:0] mask_out,
	// shared pin
	output logic shared_gpio_pin_out,
	output logic shared_gpio_pin_oe_out,
	output logic [1:0] pin_func_out
);

	function automatic logic fell(input logic prev, input logic cur);
		fell = prev & ~cur;
	endfunction

	// two-stage synchroniser for every pin input
	logic [`IWS_SYNC_W-1:0] sync1_r;
	logic [`IWS_SYNC_W-1:0] sync2_r;
	logic [`IWS_SYNC_W-1:0] sync_raw;

	assign sync_raw = {power_on_in, reset_pin_n_in, ext_irq_zero_in, ext_irq_one_in,
		low_voltage_reset_in, comparator_result_bit_in, port_pins_in};

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			sync1_r <= `IWS_SYNC_RST;
			sync2_r <= `IWS_SYNC_RST;
		end
		else
		begin
			sync1_r <= sync_raw;
			sync2_r <= sync1_r;
		end
	end

	logic por_s;
	logic rst_pin_n_s;
	logic ext0_s;
	logic ext1_s;
	logic lvr_s;
	logic cmp_s;
	logic [`IWS_PORT_W-1:0] port_s;

	assign {por_s, rst_pin_n_s, ext0_s, ext1_s, lvr_s, cmp_s, port_s} = sync2_r;

	// R13: external noise filters
	logic ext0_f;
	logic ext1_f;

	iws_noise_filter u_filt_zero
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(noise_filter_en_in),
		.level_in(ext0_s),
		.level_out(ext0_f)
	);

	iws_noise_filter u_filt_one
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.enable_in(noise_filter_en_in),
		.level_in(ext1_s),
		.level_out(ext1_f)
	);

	// state
	iws_pkg::iws_state_t state_r;
	iws_pkg::iws_state_t state_nxt;
	logic ext0_prev_r;
	logic ext1_prev_r;
	logic cmp_prev_r;
	logic [`IWS_PORT_W-1:0] port_ref_r;
	logic [`IWS_NSRC-1:0] flags_r;
	logic [`IWS_NSRC-1:0] flags_nxt;
	logic [`IWS_NSRC-1:0] mask_r;
	logic [`IWS_NSRC-1:0] sleep_mask_r;
	logic gie_r;
	logic gie_nxt;
	logic timeout_r;
	logic timeout_nxt;
	logic pdown_r;
	logic pdown_nxt;

	// R9: event detection for the five sources
	logic [`IWS_NSRC-1:0] events;
	logic port_changed;

	assign port_changed = port_s != port_ref_r;
	assign events[`IWS_SRC_TIMER] = timer_counter_ovf_in;
	// R10: reference latched by the software port read
	assign events[`IWS_SRC_PORT] = port_changed;
	assign events[`IWS_SRC_EXT0] = fell(ext0_prev_r, ext0_f);
	// R22: external pin only when selected as interrupt
	assign events[`IWS_SRC_EXT1] = ext_irq_one_select_in & fell(ext1_prev_r, ext1_f);
	// R23: every comparator change
	assign events[`IWS_SRC_CMP] = cmp_prev_r != cmp_s;

	// R1: reset causes
	logic pin_rst;
	logic wdt_rst;
	logic any_rst;
	logic asleep;

	assign pin_rst = ~rst_pin_n_s;
	assign wdt_rst = wdt_timeout_in & wdt_enable_in;
	assign any_rst = por_s | pin_rst | lvr_s | wdt_rst;
	assign asleep = state_r == iws_pkg::IWS_SLEEP;

	// R14 R17: flags set on event whatever the global enable; set wins
	logic [`IWS_NSRC-1:0] flag_keep;

	assign flag_keep = flag_wr_in ? (flags_r & flag_wr_data_in) : flags_r;
	assign flags_nxt = flag_keep | events;

	// R11: wake only from sources enabled when sleep began
	logic wake_req;
	logic pending;
	logic take;
	logic do_return;

	assign wake_req = asleep & ~any_rst & (|(flags_r & sleep_mask_r));
	// R24: one vector, sources OR-ed with no priority
	assign pending = |(flags_r & mask_r);
	assign take = ~any_rst & gie_r & pending &
		((state_r == iws_pkg::IWS_RUN) | wake_req);
	assign do_return = irq_return_instr_in & (state_r == iws_pkg::IWS_SERVICE);

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			iws_pkg::IWS_RUN:
				if (take)
					state_nxt = iws_pkg::IWS_SERVICE;
				else if (sleep_instr_in)
					state_nxt = iws_pkg::IWS_SLEEP;
			// R12: vector if global enable, else next instruction
			iws_pkg::IWS_SLEEP:
				if (take)
					state_nxt = iws_pkg::IWS_SERVICE;
				else if (wake_req)
					state_nxt = iws_pkg::IWS_RUN;
			iws_pkg::IWS_SERVICE:
				if (do_return)
					state_nxt = iws_pkg::IWS_RUN;
			default:
				state_nxt = iws_pkg::IWS_RUN;
		endcase
		if (any_rst)
			state_nxt = iws_pkg::IWS_RUN;
	end

	// R15 R19: global enable, clear beats set
	assign gie_nxt = (gie_r | global_irq_on_instr_in | irq_return_instr_in) &
		~(global_irq_off_instr_in | take | any_rst);

	// reset-cause bits, later lines win
	always_comb
	begin
		timeout_nxt = timeout_r;
		pdown_nxt = pdown_r;
		// R8: instruction effects
		if (watchdog_clear_instr_in)
			{timeout_nxt, pdown_nxt} = {1'h1, 1'h1};
		else if (sleep_instr_in & (state_r == iws_pkg::IWS_RUN) & ~take)
			{timeout_nxt, pdown_nxt} = {1'h1, 1'h0};
		// R7: wake on a source change
		if (wake_req)
			{timeout_nxt, pdown_nxt} = {1'h1, 1'h0};
		// R2 R3 R4: pin and low-voltage resets
		if ((pin_rst | lvr_s) & asleep)
			{timeout_nxt, pdown_nxt} = {1'h1, 1'h0};
		// R5 R6: watchdog clears timeout; power-down cleared from sleep
		if (wdt_rst)
			{timeout_nxt, pdown_nxt} = {1'h0, pdown_nxt & ~asleep};
		// R8: power-on sets both
		if (por_s)
			{timeout_nxt, pdown_nxt} = {`IWS_TIMEOUT_RST, `IWS_PDOWN_RST};
	end

	// shared pin function select
	iws_pkg::iws_pin_func_t pin_func;
	logic cmp_drives;

	assign cmp_drives = (comparator_pin_select_in == `IWS_CMP_SEL_OUT) |
		(comparator_pin_select_in == `IWS_CMP_SEL_OPAMP);
	// R22: interrupt first, comparator next, gpio last
	assign pin_func = ext_irq_one_select_in ? iws_pkg::IWS_PIN_EXT :
		cmp_drives ? iws_pkg::IWS_PIN_CMP : iws_pkg::IWS_PIN_GPIO;

	// R20: one-level context stack: acc, r1, r3, r4
	logic [20:0] stk_r;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= iws_pkg::IWS_RUN;
			flags_r <= '0;
			mask_r <= `IWS_MASK_RST;
			sleep_mask_r <= `IWS_MASK_RST;
			gie_r <= 1'h0;
			timeout_r <= `IWS_TIMEOUT_RST;
			pdown_r <= `IWS_PDOWN_RST;
			ext0_prev_r <= 1'h1;
			ext1_prev_r <= 1'h1;
			cmp_prev_r <= 1'h0;
			port_ref_r <= '0;
			stk_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			flags_r <= flags_nxt;
			gie_r <= gie_nxt;
			timeout_r <= timeout_nxt;
			pdown_r <= pdown_nxt;
			ext0_prev_r <= ext0_f;
			ext1_prev_r <= ext1_f;
			cmp_prev_r <= cmp_s;
			if (mask_wr_in)
				mask_r <= mask_wr_data_in;
			// R11: mask captured at the sleep instruction
			if (sleep_instr_in)
				sleep_mask_r <= mask_wr_in ? mask_wr_data_in : mask_r;
			// R10: reading the port refreshes the reference
			if (port_rd_in)
				port_ref_r <= port_s;
			// R20: push on entry
			if (take)
				stk_r <= {acc_in, r1_in, r3_in, r4_in};
		end
	end

	// registered outputs
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			reset_req_out <= 1'h0;
			wake_out <= 1'h0;
			sleeping_out <= 1'h0;
			irq_take_out <= 1'h0;
			vector_out <= '0;
			restore_valid_out <= 1'h0;
			{acc_out, r1_out, r3_out, r4_out} <= '0;
			flag_rd_out <= '0;
			shared_gpio_pin_out <= 1'h0;
			shared_gpio_pin_oe_out <= 1'h0;
			pin_func_out <= iws_pkg::IWS_PIN_GPIO;
		end
		else
		begin
			// R1: reset request to the core
			reset_req_out <= any_rst;
			// R12: wake pulse only when not vectoring
			wake_out <= wake_req & ~take;
			sleeping_out <= state_nxt == iws_pkg::IWS_SLEEP;
			// R16: fetch from the fixed vector
			irq_take_out <= take;
			vector_out <= `IWS_VECTOR;
			// R20: pop on return
			restore_valid_out <= do_return;
			if (do_return)
				{acc_out, r1_out, r3_out, r4_out} <= stk_r;
			// R18: read returns flags AND masks
			flag_rd_out <= flags_nxt & (mask_wr_in ? mask_wr_data_in : mask_r);
			shared_gpio_pin_out <= (pin_func == iws_pkg::IWS_PIN_CMP) ? cmp_s : gpio_out_val_in;
			shared_gpio_pin_oe_out <= (pin_func == iws_pkg::IWS_PIN_CMP) |
				((pin_func == iws_pkg::IWS_PIN_GPIO) & gpio_oe_in);
			pin_func_out <= pin_func;
		end
	end

	assign timeout_bit_out = timeout_r;
	assign power_down_bit_out = pdown_r;
	assign global_irq_en_out = gie_r;
	assign mask_out = mask_r;

endmodule // iws_irq_wake

/* File: hw/iws_regs.svh */
`ifndef IWS_REGS_SVH
`define IWS_REGS_SVH

// interrupt source count and bit positions
`define IWS_NSRC 5
`define IWS_SRC_TIMER 0
`define IWS_SRC_PORT 1
`define IWS_SRC_EXT0 2
`define IWS_SRC_EXT1 3
`define IWS_SRC_CMP 4

// fixed interrupt vector
`define IWS_VEC_W 10
`define IWS_VECTOR 10'h008

// change-sensing port width
`define IWS_PORT_W 8

// noise filter: pulses shorter than this many clocks are dropped
`define IWS_FILT_CLKS 8
`define IWS_FILT_CNT_W 3
`define IWS_FILT_LAST 3'h7

// synchroniser idle levels
`define IWS_SYNC_W 14
`define IWS_SYNC_RST 14'h1c00

// reset values of the cause bits and masks
`define IWS_TIMEOUT_RST 1'h1
`define IWS_PDOWN_RST 1'h1
`define IWS_MASK_RST 5'h00

// shared pin select codes
`define IWS_CMP_SEL_OUT 2'h2
`define IWS_CMP_SEL_OPAMP 2'h3

`endif

/* File: hw/iws_pkg.sv */
package iws_pkg;

	typedef enum logic [1:0] {
		IWS_RUN = 2'b00,
		IWS_SLEEP = 2'b01,
		IWS_SERVICE = 2'b10
	} iws_state_t;

	typedef enum logic [1:0] {
		IWS_PIN_GPIO = 2'b00,
		IWS_PIN_CMP = 2'b01,
		IWS_PIN_EXT = 2'b10
	} iws_pin_func_t;

endpackage

/* File: hw/iws_noise_filter.sv */
`timescale 1ns/1ps
`include "iws_regs.svh"

module iws_noise_filter
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic enable_in,
	input wire logic level_in,
	// filtered level
	output logic level_out
);

	logic [`IWS_FILT_CNT_W-1:0] cnt_r;
	logic level_r;
	logic differs;
	logic settled;

	assign differs = level_in != level_r;
	assign settled = cnt_r == `IWS_FILT_LAST;
	assign level_out = level_r;

	// when enabled, new level accepted only after eight stable clocks; when disabled, taken at once
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r <= '0;
			level_r <= 1'h1;
		end
		else if (!enable_in)
		begin
			cnt_r <= '0;
			level_r <= level_in;
		end
		else if (!differs)
			cnt_r <= '0;
		else if (settled)
		begin
			cnt_r <= '0;
			level_r <= level_in;
		end
		else
			cnt_r <= cnt_r + 3'h1;
	end

endmodule // iws_noise_filter

/* File: verif/iws_irq_wake_sva.sv */
`timescale 1ns/1ps
module iws_irq_wake_chk
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// watched inputs
	input wire logic power_on_in,
	input wire logic wdt_timeout_in,
	input wire logic wdt_enable_in,
	input wire logic irq_return_instr_in,
	input wire logic ext_irq_one_select_in,
	// watched outputs
	input wire logic timeout_bit_out,
	input wire logic power_down_bit_out,
	input wire logic sleeping_out,
	input wire logic wake_out,
	input wire logic global_irq_en_out,
	input wire logic irq_take_out,
	input wire logic restore_valid_out,
	input wire logic reset_req_out,
	input wire logic [9:0] vector_out,
	input wire logic [4:0] flag_rd_out,
	input wire logic [4:0] mask_out,
	input wire logic [1:0] pin_func_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_vector_fixed: assert property ($past(rst_n_in) |-> vector_out == 10'h008)
		else $error("vector moved");
	chk_flag_masked: assert property ((flag_rd_out & ~mask_out) == 5'h00)
		else $error("unmasked flag seen");
	chk_take_gie: assert property (irq_take_out |-> $past(global_irq_en_out) && !global_irq_en_out)
		else $error("take without global enable");
	chk_sleep_bits: assert property ($rose(sleeping_out) |-> timeout_bit_out && !power_down_bit_out)
		else $error("sleep status bits wrong");
	chk_wake_bits: assert property (wake_out |-> timeout_bit_out && !power_down_bit_out && !sleeping_out)
		else $error("wake status bits wrong");
	chk_restore_gie: assert property (restore_valid_out |-> global_irq_en_out && $past(irq_return_instr_in))
		else $error("return did not enable");
	chk_wdt_run: assert property (wdt_timeout_in && wdt_enable_in && !sleeping_out && !power_on_in |=>
		!timeout_bit_out && power_down_bit_out == $past(power_down_bit_out))
		else $error("watchdog run bits wrong");
	chk_wdt_reset: assert property (wdt_timeout_in && wdt_enable_in |-> ##[1:2] reset_req_out)
		else $error("no watchdog reset");
	chk_pin_ext: assert property (ext_irq_one_select_in [*3] |-> pin_func_out == 2'h2)
		else $error("shared pin not interrupt");
	cover property (irq_take_out);
	cover property (wake_out);
	cover property (restore_valid_out);
endmodule // iws_irq_wake_chk
bind iws_irq_wake iws_irq_wake_chk u_chk (.*);

/* File: verif/iws_seq_model.sv */
`timescale 1ns/1ps
module iws_seq_model
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// entry and routine length
	input wire logic take_in,
	input wire logic [3:0] delay_in,
	// flag clear and return strobes
	output logic clr_out,
	output logic ret_out
);
	logic [4:0] cnt_r;
	logic busy_r;
	always_ff @(posedge clk_in)
	begin
		clr_out <= 1'b0;
		ret_out <= 1'b0;
		if (!rst_n_in)
		begin
			busy_r <= 1'b0;
			cnt_r <= 5'h00;
		end
		else if (take_in)
		begin
			busy_r <= 1'b1;
			cnt_r <= {1'b0, delay_in};
		end
		else if (busy_r)
		begin
			cnt_r <= cnt_r - 5'h01;
			clr_out <= (cnt_r == 5'h01);
			ret_out <= (cnt_r == 5'h00);
			busy_r <= (cnt_r != 5'h00);
		end
	end
endmodule // iws_seq_model

/* File: verif/tb_iws_irq_wake.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
	samples_checked++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("[ERR] %s exp %h got %h", n, e, a); \
	end \
end
module tb_iws_irq_wake;
	int n_mismatch = 0;
	int samples_checked = 0;
	int i;
	logic clk_in = 0, rst_n_in = 0, power_on_in = 0, reset_pin_n_in = 1, low_voltage_reset_in = 0;
	logic wdt_timeout_in = 0, wdt_enable_in = 1, watchdog_clear_instr_in = 0, sleep_instr_in = 0;
	logic global_irq_on_instr_in = 0, global_irq_off_instr_in = 0, irq_return_instr_in, flag_wr_in, m_clr;
	logic [7:0] acc_in = 0, r4_in = 0, port_pins_in = 0, acc_out, r4_out;
	logic [1:0] r1_in = 0, comparator_pin_select_in = 0, r1_out, pin_func_out;
	logic [2:0] r3_in = 0, r3_out;
	logic timer_counter_ovf_in = 0, ext_irq_zero_in = 1, ext_irq_one_in = 1, comparator_result_bit_in = 0;
	logic port_rd_in = 0, tb_fw = 0, mask_wr_in = 0, noise_filter_en_in = 1, ext_irq_one_select_in = 0;
	logic gpio_out_val_in = 1, gpio_oe_in = 1, reset_req_out, timeout_bit_out, power_down_bit_out;
	logic [4:0] tb_fd = 0, flag_wr_data_in, mask_wr_data_in = 0, flag_rd_out, mask_out;
	logic [3:0] m_dly = 0;
	logic [9:0] vector_out;
	logic sleeping_out, wake_out, global_irq_en_out, irq_take_out, restore_valid_out;
	logic shared_gpio_pin_out, shared_gpio_pin_oe_out;
	assign flag_wr_in = tb_fw | m_clr;
	assign flag_wr_data_in = m_clr ? 5'h1e : tb_fd;
	always #4 clk_in = ~clk_in;
	iws_irq_wake u_dut (.*);
	iws_seq_model u_seq (.clk_in(clk_in), .rst_n_in(rst_n_in), .take_in(irq_take_out), .delay_in(m_dly),
		.clr_out(m_clr), .ret_out(irq_return_instr_in));
	task cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task mask(input logic [4:0] m);
		mask_wr_data_in = m;
		mask_wr_in = 1;
		cyc(1);
		mask_wr_in = 0;
	endtask
	task fclr();
		tb_fw = 1;
		cyc(1);
		tb_fw = 0;
	endtask
	task slp();
		sleep_instr_in = 1;
		cyc(1);
		sleep_instr_in = 0;
	endtask
	task wdt();
		wdt_timeout_in = 1;
		cyc(1);
		wdt_timeout_in = 0;
		cyc(3);
	endtask
	task wt(input int w);
		i = 0;
		while ((w == 0 ? wake_out : w == 1 ? irq_take_out : restore_valid_out) !== 1'b1 && i < 40)
		begin
			cyc(1);
			i++;
		end
	endtask
	task t_flags();
		`CHK("tbit", 1'b1, timeout_bit_out)
		`CHK("vec", 10'h008, vector_out)
		`CHK("mask", 5'h00, mask_out)
		mask(5'h01);
		timer_counter_ovf_in = 1;
		comparator_result_bit_in = 1;
		cyc(1);
		timer_counter_ovf_in = 0;
		cyc(5);
		`CHK("flag and", 5'h01, flag_rd_out)
		mask(5'h1f);
		cyc(1);
		`CHK("two flags", 5'h11, flag_rd_out)
		fclr();
		comparator_result_bit_in = 0;
		cyc(5);
		`CHK("cmp change", 5'h10, flag_rd_out)
		fclr();
		$display("flags done");
	endtask
	task t_ext();
		ext_irq_zero_in = 0;
		cyc(7);
		ext_irq_zero_in = 1;
		cyc(12);
		`CHK("short", 5'h00, flag_rd_out)
		ext_irq_zero_in = 0;
		cyc(14);
		`CHK("long", 5'h04, flag_rd_out)
		ext_irq_zero_in = 1;
		noise_filter_en_in = 0;
		ext_irq_one_select_in = 1;
		ext_irq_one_in = 0;
		cyc(3);
		ext_irq_one_in = 1;
		cyc(8);
		`CHK("unfiltered", 5'h0c, flag_rd_out)
		noise_filter_en_in = 1;
		fclr();
		mask(5'h00);
		$display("ext done");
	endtask
	task t_cause();
		wdt_enable_in = 0;
		wdt();
		`CHK("wdt off", 1'b1, timeout_bit_out)
		wdt_enable_in = 1;
		wdt();
		`CHK("wdt t", 1'b0, timeout_bit_out)
		`CHK("wdt p", 1'b1, power_down_bit_out)
		reset_pin_n_in = 0;
		cyc(4);
		reset_pin_n_in = 1;
		cyc(4);
		`CHK("pin t", 1'b0, timeout_bit_out)
		`CHK("pin p", 1'b1, power_down_bit_out)
		watchdog_clear_instr_in = 1;
		cyc(1);
		watchdog_clear_instr_in = 0;
		`CHK("clr t", 1'b1, timeout_bit_out)
		slp();
		`CHK("slp p", 1'b0, power_down_bit_out)
		port_pins_in = 8'h01;
		cyc(6);
		`CHK("no wake", 1'b1, sleeping_out)
		wdt();
		`CHK("wdt wake", 2'h0, {timeout_bit_out, power_down_bit_out})
		port_rd_in = 1;
		cyc(1);
		port_rd_in = 0;
		fclr();
		mask(5'h02);
		slp();
		port_pins_in = 8'h00;
		wt(0);
		`CHK("wake", 1'b1, wake_out)
		`CHK("wake tp", 2'h2, {timeout_bit_out, power_down_bit_out})
		port_rd_in = 1;
		cyc(1);
		port_rd_in = 0;
		fclr();
		mask(5'h00);
		for (int k = 0; k < 2; k++)
		begin
			wdt();
			slp();
			low_voltage_reset_in = k;
			reset_pin_n_in = k;
			cyc(4);
			low_voltage_reset_in = 0;
			reset_pin_n_in = 1;
			cyc(4);
			`CHK("rst wake", 3'h4, {timeout_bit_out, power_down_bit_out, sleeping_out})
		end
		$display("causes done");
	endtask
	task t_irq(input logic [3:0] d);
		m_dly = d;
		{acc_in, r1_in, r3_in, r4_in} = {8'ha5, 2'h2, 3'h5, 8'h3c};
		mask(5'h01);
		global_irq_on_instr_in = 1;
		cyc(1);
		global_irq_on_instr_in = 0;
		`CHK("gie on", 1'b1, global_irq_en_out)
		timer_counter_ovf_in = 1;
		cyc(1);
		timer_counter_ovf_in = 0;
		wt(1);
		`CHK("take", 2'h2, {irq_take_out, global_irq_en_out})
		{acc_in, r1_in, r3_in, r4_in} = 0;
		wt(2);
		`CHK("ctx", {1'b1, 8'ha5, 2'h2, 3'h5, 8'h3c}, {restore_valid_out, acc_out, r1_out, r3_out, r4_out})
		`CHK("gie ret", 1'b1, global_irq_en_out)
		`CHK("served", 5'h00, flag_rd_out)
		global_irq_off_instr_in = 1;
		cyc(1);
		global_irq_off_instr_in = 0;
		`CHK("gie off", 1'b0, global_irq_en_out)
		$display("irq done");
	endtask
	task pf(input logic e, input logic [1:0] c, input logic [1:0] f, input logic o);
		ext_irq_one_select_in = e;
		comparator_pin_select_in = c;
		cyc(3);
		`CHK("pin func", {f, o}, {pin_func_out, shared_gpio_pin_oe_out})
	endtask
	task t_pin();
		pf(1'b1, 2'h2, 2'h2, 1'b0);
		pf(1'b0, 2'h2, 2'h1, 1'b1);
		`CHK("cmp drive", 1'b0, shared_gpio_pin_out)
		pf(1'b0, 2'h3, 2'h1, 1'b1);
		pf(1'b0, 2'h1, 2'h0, 1'b1);
		`CHK("gpio", 1'b1, shared_gpio_pin_out)
		$display("pin done");
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		cyc(10);
		rst_n_in = 1;
		cyc(3);
		t_flags();
		t_ext();
		t_cause();
		t_irq(4'h2);
		t_irq(4'h9);
		t_pin();
		end_of_test();
	end
	initial
	begin
		#40000;
		n_mismatch++;
		end_of_test();
	end
endmodule // tb_iws_irq_wake
